// File: verilog/ne_clock_map.svh
/*
  Constants for the element time-of-day clock and the failure persistency
  filter: timing counts, reset date and field limits.
  Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef NE_CLOCK_MAP_SVH
`define NE_CLOCK_MAP_SVH

// Clock and tick timing
`define SYS_CLK_PERIOD_NS 10
`define SUBTICK_MS        100
`define SUBTICK_CYCLES    ((`SUBTICK_MS * 1000000) / `SYS_CLK_PERIOD_NS)
`define TICKS_PER_SEC     (1000 / `SUBTICK_MS)

// Persistency times
`define DECLARE_MS        2500
`define CLEAR_MS          10000
`define DECLARE_TICKS     (`DECLARE_MS / `SUBTICK_MS)
`define CLEAR_TICKS       (`CLEAR_MS / `SUBTICK_MS)

// Reset date and time: 2000-01-01 00:00:00
`define RST_YEAR          12'h7d0
`define RST_MONTH         4'h1
`define RST_DAY           5'h01
`define RST_HOUR          5'h00
`define RST_MINUTE        6'h00
`define RST_SECOND        6'h00

// Field limits
`define SEC_LAST          6'h3b
`define MIN_LAST          6'h3b
`define HOUR_LAST         5'h17
`define MONTH_LAST        4'hc

`endif

// File: verilog/ne_clock_pkg.sv
/*
  Types shared by the element clock and the failure filter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ne_clock_pkg;

  // Date and time of day, one-second resolution
  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
  } date_time_s;

  typedef enum logic {
    FS_CLEARED = 1'b0,
    FS_FAILED  = 1'b1
  } filter_state_e;

  typedef logic [1:0] severity_t;

  localparam int STAMP_W = $bits(date_time_s);

endpackage

// File: verilog/tick_if.sv
/*
  Carrier from the element clock to each filter channel: sub-second tick
  and the current date-time.
  Assumes one sys_clk domain for both ends.
*/
`timescale 1ns/1ns
interface tick_if;
  import ne_clock_pkg::*;
  logic       tick;
  date_time_s now;
  modport src (output tick, output now);
  modport dst (input tick, input now);
endinterface

// File: verilog/failure_persistency_filter.sv
/*
  One channel of the failure persistency filter: integrates a fault cause
  into a declared or cleared failure and stamps each change.
  Assumes the cause comes from logic on sys_clk and the tick from tick_if.
*/
`timescale 1ns/1ns
`include "ne_clock_map.svh"
module failure_persistency_filter
  import ne_clock_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  tick_if.dst             tb,
  input  wire logic       fault_cause,
  input  wire severity_t  severity_cfg,
  output logic            failure,
  output logic            failure_change,
  output severity_t       alarm_severity,
  output date_time_s      change_stamp
);
  localparam int DECL_T = `DECLARE_TICKS;
  localparam int CLR_T  = `CLEAR_TICKS;

  filter_state_e state_r;
  logic          cause_r;
  logic [7:0]    cnt_r;
  date_time_s    start_r;
  logic          change_r;
  severity_t     sev_r;
  date_time_s    stamp_r;

  // Pending means the cause disagrees with the declared state
  wire        toggle  = fault_cause != cause_r;
  wire        pending = (state_r == FS_CLEARED) ? cause_r : !cause_r;
  wire [7:0]  target  = (state_r == FS_CLEARED) ? 8'(DECL_T) : 8'(CLR_T);
  wire        fire    = pending && !toggle && tb.tick &&
                        (cnt_r == target - 8'h01);

  // Integration restarts on every toggle so a flicker never accumulates
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cause_r <= 1'b0;
      cnt_r   <= 8'h00;
      start_r <= '0;
    end else begin
      cause_r <= fault_cause;
      if (toggle) begin
        cnt_r   <= 8'h00;
        start_r <= tb.now;
      end else if (fire) begin
        cnt_r <= 8'h00;
      end else if (tb.tick && pending) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // Change of state and stamp are taken on every fire, severity only on a declare fire
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= FS_CLEARED;
      change_r <= 1'b0;
      sev_r    <= 2'h0;
      stamp_r  <= '0;
    end else begin
      change_r <= fire;
      if (fire) begin
        case (state_r)
          FS_CLEARED: state_r <= FS_FAILED;
          FS_FAILED:  state_r <= FS_CLEARED;
          default:    state_r <= FS_CLEARED;
        endcase
        stamp_r <= start_r;
        if (state_r == FS_CLEARED) begin
          sev_r <= severity_cfg;
        end
      end
    end
  end

  assign failure        = state_r == FS_FAILED;
  assign failure_change = change_r;
  assign alarm_severity = sev_r;
  assign change_stamp   = stamp_r;

  declare_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(failure) |-> $past(cnt_r) == 8'(DECL_T - 1) && $past(cause_r))
    else $error("failure declared at wrong count");

  clear_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(failure) |-> $past(cnt_r) == 8'(CLR_T - 1) && !$past(cause_r))
    else $error("failure cleared at wrong count");

  change_stamped_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    failure_change |-> change_stamp == $past(start_r)
                       && failure != $past(failure, 2))
    else $error("change stamp not integration start");

  severity_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(failure) |-> alarm_severity == $past(severity_cfg))
    else $error("severity not taken on declare");

endmodule // failure_persistency_filter

// File: verilog/element_time_of_day.sv
/*
  Equipment management block top: date and time-of-day clock with one
  second resolution, plus a bank of failure persistency filters that are
  stamped against it.
  Assumes fault causes, severity settings and set commands come from logic
  on sys_clk; the equipment timing pulse is a pin and is synchronised.
*/
`timescale 1ns/1ns
`include "ne_clock_map.svh"
module element_time_of_day
  import ne_clock_pkg::*;
#(
  parameter int          CHANNELS    = 4,
  parameter int unsigned TICK_CYCLES = `SUBTICK_CYCLES
)(
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic                        set_valid,
  input  wire date_time_s                  set_value,
  input  wire logic                        lock_enable,
  input  wire logic                        equipment_timing_clock,
  input  wire logic [CHANNELS-1:0]         fault_cause,
  input  wire logic [2*CHANNELS-1:0]       severity_cfg,
  output date_time_s                       time_now,
  output logic                             second_pulse,
  output logic [CHANNELS-1:0]              failure,
  output logic [CHANNELS-1:0]              failure_change,
  output logic [2*CHANNELS-1:0]            alarm_severity,
  output logic [STAMP_W*CHANNELS-1:0]      change_stamp
);
  localparam int TW     = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int TPS    = `TICKS_PER_SEC;
  localparam date_time_s RST_TIME = '{
    year: `RST_YEAR, month: `RST_MONTH, day: `RST_DAY,
    hour: `RST_HOUR, minute: `RST_MINUTE, second: `RST_SECOND};

  // The tick must be at least two cycles and the bank non-empty
  if (CHANNELS < 1 || TICK_CYCLES < 2) begin : bad_param
    $error("element_time_of_day: unsupported parameters");
  end

  // Days in a month, with Gregorian leap years so 2000 is leap
  function automatic logic [4:0] month_days(input logic [11:0] y,
                                            input logic [3:0]  m);
    logic leap;
    leap = (y % 12'd4 == 12'd0) &&
           ((y % 12'd100 != 12'd0) || (y % 12'd400 == 12'd0));
    case (m)
      4'h2:                   month_days = leap ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
      default:                month_days = 5'h1f;
    endcase
  endfunction

  // One second forward, carrying through every field
  function automatic date_time_s advance(input date_time_s t);
    date_time_s n;
    n = t;
    if (t.second != `SEC_LAST) begin
      n.second = t.second + 6'h01;
    end else begin
      n.second = 6'h00;
      if (t.minute != `MIN_LAST) begin
        n.minute = t.minute + 6'h01;
      end else begin
        n.minute = 6'h00;
        if (t.hour != `HOUR_LAST) begin
          n.hour = t.hour + 5'h01;
        end else begin
          n.hour = 5'h00;
          if (t.day < month_days(t.year, t.month)) begin
            n.day = t.day + 5'h01;
          end else begin
            n.day = 5'h01;
            if (t.month < `MONTH_LAST) begin
              n.month = t.month + 4'h1;
            end else begin
              n.month = 4'h1;
              n.year  = t.year + 12'h001;
            end
          end
        end
      end
    end
    advance = n;
  endfunction

  logic [TW-1:0] cyc_r;
  logic [7:0]    sub_r;
  logic          pps_s1_r;
  logic          pps_s2_r;
  logic          pps_s3_r;
  date_time_s    now_r;
  logic          sec_r;

  // Sub-second tick and the local second that it builds
  wire tick      = cyc_r == TW'(TICK_CYCLES - 1);
  wire local_sec = tick && (sub_r == 8'(TPS - 1));
  wire pps_edge  = pps_s2_r && !pps_s3_r;
  // A set command wins over a second edge in the same cycle
  wire sec_step  = !set_valid &&
                   (lock_enable ? pps_edge : local_sec);

  // Prescaler restarts on a set so the first second is a full one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_r <= '0;
      sub_r <= 8'h00;
    end else if (set_valid || tick) begin
      cyc_r <= '0;
      if (set_valid || local_sec) begin
        sub_r <= 8'h00;
      end else begin
        sub_r <= sub_r + 8'h01;
      end
    end else begin
      cyc_r <= cyc_r + TW'(1);
    end
  end

  // Equipment timing pulse is a pin: two flops, then a third for the edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pps_s1_r <= 1'b0;
      pps_s2_r <= 1'b0;
      pps_s3_r <= 1'b0;
    end else begin
      pps_s1_r <= equipment_timing_clock;
      pps_s2_r <= pps_s1_r;
      pps_s3_r <= pps_s2_r;
    end
  end

  // Date and time registers; no range check on a set, software owns it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      now_r <= RST_TIME;
      sec_r <= 1'b0;
    end else begin
      sec_r <= sec_step;
      if (set_valid) begin
        now_r <= set_value;
      end else if (sec_step) begin
        now_r <= advance(now_r);
      end
    end
  end

  assign time_now     = now_r;
  assign second_pulse = sec_r;

  // Filters share the tick and stamp against the live clock
  tick_if tb ();
  assign tb.tick = tick;
  assign tb.now  = now_r;

  for (genvar i = 0; i < CHANNELS; i++) begin : chan
    date_time_s stamp_w;
    severity_t  sev_w;
    failure_persistency_filter u_filt (
      .sys_clk        (sys_clk),
      .nrst           (nrst),
      .tb             (tb),
      .fault_cause    (fault_cause[i]),
      .severity_cfg   (severity_cfg[2*i +: 2]),
      .failure        (failure[i]),
      .failure_change (failure_change[i]),
      .alarm_severity (sev_w),
      .change_stamp   (stamp_w)
    );
    assign alarm_severity[2*i +: 2]          = sev_w;
    assign change_stamp[STAMP_W*i +: STAMP_W] = stamp_w;
  end

  set_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    set_valid |=> time_now == $past(set_value))
    else $error("set command not loaded");

  sec_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sec_step && now_r.second != `SEC_LAST
      |=> time_now.second == $past(now_r.second) + 6'h01 && second_pulse)
    else $error("second did not advance");

  sec_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sec_step && !set_valid |=> $stable(time_now))
    else $error("clock moved without a second");

  minute_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sec_step && now_r.second == `SEC_LAST && now_r.minute != `MIN_LAST
      |=> time_now.second == 6'h00
          && time_now.minute == $past(now_r.minute) + 6'h01)
    else $error("minute carry wrong");

  field_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(set_valid) == 1'b0 && !set_valid
      |-> time_now.second <= `SEC_LAST || $past(time_now.second) > `SEC_LAST)
    else $error("second field out of range");

  // Reference second for the free-run checks, kept apart from the prescaler
  // so that a broken tick or sub count cannot hide behind itself
  localparam int unsigned SEC_CYCLES = TPS * TICK_CYCLES;
  localparam int          PW         = $clog2(SEC_CYCLES);
  logic [PW-1:0] phase_r;
  logic          free_r;

  // Phase restarts on a set; reset, or a set made while free-running, arms it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= '0;
      free_r  <= 1'b1;
    end else begin
      if (set_valid || phase_r == PW'(SEC_CYCLES - 1)) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + PW'(1);
      end
      if (lock_enable) begin
        free_r <= 1'b0;
      end else if (set_valid) begin
        free_r <= 1'b1;
      end
    end
  end

  local_rate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    free_r && !lock_enable && sec_step |-> phase_r == PW'(SEC_CYCLES - 1))
    else $error("free-run second off its period");

  free_period_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    free_r && !lock_enable && !set_valid && phase_r == PW'(SEC_CYCLES - 1)
      |-> sec_step)
    else $error("free-run second missed");

endmodule // element_time_of_day

// File: test/timing_source.sv
/*
  Model of the equipment timing source seen by the element clock: one
  rising edge on the pin per period while running.
  Assumes it shares sys_clk with the bench; the pin rests low when stopped.
*/
`timescale 1ns/1ns
module timing_source #(
  parameter int PERIOD = 30
)(
  input  wire logic sys_clk,
  input  wire logic run,
  output logic      equipment_timing_clock
);
  int cnt_r;

  // High for the first half of each period; stands still when not run
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      cnt_r                  <= 0;
      equipment_timing_clock <= 1'b0;
    end else begin
      cnt_r                  <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      equipment_timing_clock <= (cnt_r < PERIOD / 2);
    end
  end
endmodule // timing_source

// File: test/test_element_time_of_day.sv
/*
  Self-checking bench for the element clock and its failure filters.
  Assumes a short tick (4 cycles) so one second is 40 cycles.
*/
`timescale 1ns/1ns
module test_element_time_of_day;
  import ne_clock_pkg::*;
  logic             sys_clk;
  logic             nrst;
  logic             set_valid;
  date_time_s       set_value;
  logic             lock_enable;
  logic             run;
  logic             equipment_timing_clock;
  logic [1:0]       fault_cause;
  logic [3:0]       severity_cfg;
  date_time_s       time_now;
  logic             second_pulse;
  logic [1:0]       failure;
  logic [1:0]       failure_change;
  logic [3:0]       alarm_severity;
  logic [75:0]      change_stamp;
  int               n_errors;
  int               cmp_count;
  int               n;
  int               chg_cnt;

  element_time_of_day #(.CHANNELS(2), .TICK_CYCLES(4)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .set_valid(set_valid),
    .set_value(set_value), .lock_enable(lock_enable),
    .equipment_timing_clock(equipment_timing_clock),
    .fault_cause(fault_cause), .severity_cfg(severity_cfg),
    .time_now(time_now), .second_pulse(second_pulse),
    .failure(failure), .failure_change(failure_change),
    .alarm_severity(alarm_severity), .change_stamp(change_stamp));

  timing_source #(.PERIOD(30)) src (.sys_clk(sys_clk), .run(run),
    .equipment_timing_clock(equipment_timing_clock));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Counts change pulses so a glitch that leaks through is seen
  // Sampled on the falling edge, where the registered pulse has settled
  always @(negedge sys_clk) if (failure_change[0] === 1'b1) chg_cnt++;

  function automatic date_time_s dt(input logic [11:0] y, input logic [3:0] m,
    input logic [4:0] d, input logic [4:0] h, input logic [5:0] mi,
    input logic [5:0] s);
    dt = '{year: y, month: m, day: d, hour: h, minute: mi, second: s};
  endfunction

  task automatic check(input string what, input logic [37:0] got,
    input logic [37:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Set takes effect one edge after the strobe
  task automatic do_set(input date_time_s v);
    @(negedge sys_clk);
    set_valid = 1'b1;
    set_value = v;
    @(negedge sys_clk);
    set_valid = 1'b0;
    check("time after set", time_now, v);
  endtask

  // Bounded wait for a second step, sampled on falling edges
  task automatic wait_step(input int limit);
    n = 0;
    while (second_pulse !== 1'b1 && n < limit) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // Bounded wait for a filter change on channel 0
  task automatic wait_change(input int limit);
    n = 0;
    while (failure_change[0] !== 1'b1 && n < limit) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic test_reset;
    check("reset time", time_now, dt(12'h7d0, 4'h1, 5'h01, 5'h00, 6'h00,
      6'h00));
    check("reset failure", 38'(failure), 38'h0);
    $display("test reset done");
  endtask

  // Free-run steps across day, month, leap and century boundaries
  task automatic test_rollover;
    date_time_s from [4];
    date_time_s to [4];
    from[0] = dt(12'h7d0, 4'h2, 5'h1c, 5'h17, 6'h3b, 6'h3b);
    to[0]   = dt(12'h7d0, 4'h2, 5'h1d, 5'h00, 6'h00, 6'h00);
    from[1] = dt(12'h7cf, 4'hc, 5'h1f, 5'h17, 6'h3b, 6'h3b);
    to[1]   = dt(12'h7d0, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00);
    from[2] = dt(12'h834, 4'h2, 5'h1c, 5'h17, 6'h3b, 6'h3b);
    to[2]   = dt(12'h834, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00);
    from[3] = dt(12'h7d1, 4'h4, 5'h1e, 5'h17, 6'h3b, 6'h3b);
    to[3]   = dt(12'h7d1, 4'h5, 5'h01, 5'h00, 6'h00, 6'h00);
    for (int i = 0; i < 4; i++) begin
      do_set(from[i]);
      wait_step(60);
      check("second span", 38'(n >= 37 && n <= 42), 38'h1);
      check("rolled time", time_now, to[i]);
    end
    $display("test rollover done");
  endtask

  // Locked seconds follow the pin, not the local tick
  task automatic test_lock;
    @(negedge sys_clk);
    lock_enable = 1'b1;
    do_set(dt(12'h7d0, 4'h6, 5'h0f, 5'h0c, 6'h00, 6'h05));
    run = 1'b1;
    wait_step(40);
    @(negedge sys_clk);
    wait_step(40);
    check("locked span", 38'(n >= 28 && n <= 31), 38'h1);
    // Realignment as a manager makes it: clock shows :07, moved by 2 s
    do_set(dt(12'h7d0, 4'h6, 5'h0f, 5'h0c, 6'h00, 6'h09));
    @(negedge sys_clk);
    run = 1'b0;
    wait_step(100);
    check("no step when pin idle", 38'(n), 38'd100);
    lock_enable = 1'b0;
    $display("test lock done");
  endtask

  // Short cause is ignored; long cause declares, absence clears
  task automatic test_filter;
    date_time_s v1;
    date_time_s v2;
    v1 = dt(12'h7d2, 4'h3, 5'h0a, 5'h08, 6'h1e, 6'h00);
    v2 = dt(12'h7d2, 4'h3, 5'h0a, 5'h09, 6'h00, 6'h14);
    chg_cnt = 0;
    fault_cause[0] = 1'b1;
    repeat (80) @(negedge sys_clk);
    fault_cause[0] = 1'b0;
    repeat (20) @(negedge sys_clk);
    check("glitch changes", 38'(chg_cnt), 38'h0);
    do_set(v1);
    @(negedge sys_clk);
    fault_cause = 2'h3;
    wait_change(120);
    check("declare span", 38'(n >= 95 && n <= 102), 38'h1);
    check("declared", 38'(failure), 38'h3);
    check("declare pulses", 38'(failure_change), 38'h3);
    check("declare stamp", change_stamp[37:0], v1);
    check("declare stamp 1", change_stamp[75:38], v1);
    check("severity", 38'(alarm_severity[1:0]), 38'h3);
    check("severity 1", 38'(alarm_severity[3:2]), 38'h1);
    severity_cfg = 4'h8;
    do_set(v2);
    @(negedge sys_clk);
    fault_cause = 2'h0;
    wait_change(420);
    check("clear span", 38'(n >= 395 && n <= 402), 38'h1);
    check("cleared", 38'(failure), 38'h0);
    check("clear pulses", 38'(failure_change), 38'h3);
    check("clear stamp", change_stamp[37:0], v2);
    check("clear stamp 1", change_stamp[75:38], v2);
    check("severity held", 38'(alarm_severity[1:0]), 38'h3);
    check("severity held 1", 38'(alarm_severity[3:2]), 38'h1);
    $display("test filter done");
  endtask

  // Watchdog well beyond the expected 940 or so cycles
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    n_errors = 0;
    cmp_count = 0;
    chg_cnt = 0;
    nrst = 1'b0;
    set_valid = 1'b0;
    set_value = '0;
    lock_enable = 1'b0;
    run = 1'b0;
    fault_cause = 2'h0;
    severity_cfg = 4'h7;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    test_reset();
    test_rollover();
    test_lock();
    test_filter();
    end_of_test();
  end
endmodule // test_element_time_of_day
